/* csc_status_bank.sv */
// Controller protocol, mode, comms and fault status/configuration bank
// Notes on behaviour
// - Missing output written without extension: fault 41H
// - Primary bit picks protocol tried first
// - Active protocol bit follows each protocol switch, except one in the same cycle as a power-up
// - Status bit shows full or half duplex
// - Five-bit mode field with fixed codes
// - Forces-enabled bit always reads one
// - Forces-installed bit set while forces applied
// - Valid received data sets comms active
// - Serial: ten idle seconds clear comms active
// - Half duplex: only command polls restart timer
// - Token: no other stations clears comms active
// - Override at power-up clears faults, resumes run
// - Major error sets halted bit and code
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module csc_status_bank import csc_pkg::*; #(
   parameter int unsigned INACT_CYCLES = CSC_INACT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [CSC_ADDR_W-1:0] i_addr,
   input wire logic [CSC_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [CSC_DATA_W-1:0] o_rdata,
   input wire logic i_out_wr,
   input wire logic i_out_exists,
   input wire logic i_major_err,
   input wire logic [15:0] i_major_code,
   input wire logic [7:0] i_minor_set,
   input wire logic i_mode_wr,
   input wire logic [4:0] i_mode_code,
   input wire logic i_powerup,
   input wire logic i_proto_switch,
   input wire logic i_half_duplex,
   input wire logic i_forces_installed,
   input wire logic i_rx_valid,
   input wire logic i_rx_cmd,
   input wire logic i_link_alone,
   output logic o_active_protocol,
   output logic [4:0] o_mode,
   output logic o_halted,
   output logic o_comms_active,
   output logic o_run_request,
   output logic o_irq
);
   typedef struct packed {
      logic ext_io;
      logic primary;
      logic active;
      logic comms;
      logic flt_ovr;
      logic halted;
      logic [4:0] mode;
      logic [7:0] minor;
      logic [15:0] fault_code;
      logic [CSC_IRQ_W-1:0] irq_stat;
      logic [CSC_IRQ_W-1:0] irq_en;
      logic run_req;
      logic [CSC_DATA_W-1:0] rdata;
   } csc_bank_s;

   csc_bank_s st_r;
   csc_bank_s st_nxt;
   logic timer_run;
   logic timer_restart;
   logic timer_expired;
   logic bad_output;
   logic overrides;
   logic [CSC_DATA_W-1:0] proto_word;
   logic [CSC_DATA_W-1:0] mode_word;

   // Only the point-to-point serial protocol runs the idle timer
   assign timer_run = st_r.comms && (st_r.active == CSC_PROTO_SERIAL);
   // Simple polls and replies do not keep the link alive in half duplex
   assign timer_restart = i_rx_valid && (!i_half_duplex || i_rx_cmd);

   csc_idle_timer #(
      .COUNT(INACT_CYCLES)
   ) u_idle (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_run(timer_run),
      .i_restart(timer_restart),
      .o_expired(timer_expired)
   );

   assign bad_output = i_out_wr && !i_out_exists && !st_r.ext_io;
   assign overrides = i_powerup && st_r.flt_ovr && st_r.halted && (st_r.mode == CSC_MODE_RUN);

   // Reserved positions are constant zero and have no storage
   always_comb begin
      proto_word = '0;
      proto_word[CSC_B_EXT_IO] = st_r.ext_io;
      proto_word[CSC_B_PRIMARY] = st_r.primary;
      proto_word[CSC_B_ACTIVE] = st_r.active;
      proto_word[CSC_B_HALF_DPX] = i_half_duplex;
      mode_word = '0;
      mode_word[CSC_B_MODE_LSB +: 5] = st_r.mode;
      mode_word[CSC_B_FORCE_EN] = 1'b1;
      mode_word[CSC_B_FORCE_IN] = i_forces_installed;
      mode_word[CSC_B_COMMS] = st_r.comms;
      mode_word[CSC_B_FLT_OVR] = st_r.flt_ovr;
      mode_word[CSC_B_HALTED] = st_r.halted;
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.run_req = 1'b0;
      st_nxt.rdata = '0;

      // Software writes: configuration fields, the halted bit and the minor fault bits take write data
      if (i_wr) begin
         if (i_addr == CSC_OFS_PROTO) begin
            st_nxt.ext_io = i_wdata[CSC_B_EXT_IO];
            st_nxt.primary = i_wdata[CSC_B_PRIMARY];
         end else if (i_addr == CSC_OFS_MODE) begin
            // Host is trusted to change the override bit while offline
            st_nxt.flt_ovr = i_wdata[CSC_B_FLT_OVR];
            st_nxt.halted = i_wdata[CSC_B_HALTED];
         end else if (i_addr == CSC_OFS_IRQ_EN) begin
            st_nxt.irq_en = i_wdata[CSC_IRQ_W-1:0];
         end else if (i_addr == CSC_OFS_IRQ_CLR) begin
            st_nxt.irq_stat = st_r.irq_stat & ~i_wdata[CSC_IRQ_W-1:0];
         end else if (i_addr == CSC_OFS_MINOR) begin
            st_nxt.minor = i_wdata[7:0];
         end
      end

      if (i_mode_wr) begin
         st_nxt.mode = i_mode_code;
      end

      st_nxt.minor = st_nxt.minor | i_minor_set;

      // Protocol selection; a power-up starts again from the primary choice
      if (i_powerup) begin
         st_nxt.active = st_r.primary;
      end else if (i_proto_switch) begin
         st_nxt.active = ~st_r.active;
         st_nxt.irq_stat[CSC_I_PROTO_SW] = 1'b1;
      end

      // Comms active: loss first so a reception in the same cycle wins
      if (timer_expired && st_r.active == CSC_PROTO_SERIAL) begin
         st_nxt.comms = 1'b0;
      end
      if (i_link_alone && st_r.active == CSC_PROTO_TOKEN) begin
         st_nxt.comms = 1'b0;
      end
      if (i_rx_valid) begin
         st_nxt.comms = 1'b1;
      end
      if (st_r.comms && !st_nxt.comms) begin
         st_nxt.irq_stat[CSC_I_COMMS_LOST] = 1'b1;
      end

      // Power-up recovery from a run-mode fault
      if (overrides) begin
         st_nxt.halted = 1'b0;
         st_nxt.minor = 8'h00;
         st_nxt.mode = CSC_MODE_RUN;
         st_nxt.run_req = 1'b1;
      end

      // Faults last: a hardware set beats a software clear of the halted bit
      if (bad_output) begin
         st_nxt.halted = 1'b1;
         st_nxt.fault_code = CSC_FC_NO_OUTPUT;
         st_nxt.irq_stat[CSC_I_FAULT] = 1'b1;
      end else if (i_major_err) begin
         st_nxt.halted = 1'b1;
         st_nxt.fault_code = i_major_code;
         st_nxt.irq_stat[CSC_I_FAULT] = 1'b1;
      end

      // Read data stands for the cycle after the strobe only
      if (i_rd) begin
         if (i_addr == CSC_OFS_PROTO) begin
            st_nxt.rdata = proto_word;
         end else if (i_addr == CSC_OFS_MODE) begin
            st_nxt.rdata = mode_word;
         end else if (i_addr == CSC_OFS_IRQ_STAT) begin
            st_nxt.rdata = {13'h0000, st_r.irq_stat};
         end else if (i_addr == CSC_OFS_IRQ_EN) begin
            st_nxt.rdata = {13'h0000, st_r.irq_en};
         end else if (i_addr == CSC_OFS_FAULT) begin
            st_nxt.rdata = st_r.fault_code;
         end else if (i_addr == CSC_OFS_MINOR) begin
            st_nxt.rdata = {8'h00, st_r.minor};
         end else begin
            st_nxt.rdata = '0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
         st_r.ext_io <= CSC_RST_EXT_IO;
         st_r.primary <= CSC_RST_PRIMARY;
         st_r.active <= CSC_RST_PRIMARY;
         st_r.flt_ovr <= CSC_RST_FLT_OVR;
         st_r.mode <= CSC_RST_MODE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rdata = st_r.rdata;
   assign o_active_protocol = st_r.active;
   assign o_mode = st_r.mode;
   assign o_halted = st_r.halted;
   assign o_comms_active = st_r.comms;
   assign o_run_request = st_r.run_req;
   assign o_irq = |(st_r.irq_stat & st_r.irq_en);

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_no_output_fault;
      bad_output |=> o_halted && st_r.fault_code == CSC_FC_NO_OUTPUT && st_r.irq_stat[CSC_I_FAULT];
   endproperty
   a_no_output_fault: assert property (p_no_output_fault) else $error("missing output did not fault");

   property p_ext_io_blocks;
      (i_out_wr && st_r.ext_io && !i_major_err && !$past(o_halted) && !o_halted && !i_wr) |=> !o_halted;
   endproperty
   a_ext_io_blocks: assert property (p_ext_io_blocks) else $error("extended output wrongly faulted");

   property p_powerup_primary;
      i_powerup |=> o_active_protocol == $past(st_r.primary);
   endproperty
   a_powerup_primary: assert property (p_powerup_primary) else $error("power-up protocol not primary");

   property p_switch_toggles;
      (i_proto_switch && !i_powerup) |=> o_active_protocol != $past(o_active_protocol);
   endproperty
   a_switch_toggles: assert property (p_switch_toggles) else $error("protocol switch not shown");

   property p_mode_read;
      (i_rd && i_addr == CSC_OFS_MODE) |=> o_rdata[5] && o_rdata[4:0] == $past(o_mode) && o_rdata[12:9] == 4'h0;
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode word read wrong");

   property p_proto_read;
      (i_rd && i_addr == CSC_OFS_PROTO) |=> o_rdata[12] == $past(i_half_duplex) && o_rdata[9] == 1'b0;
   endproperty
   a_proto_read: assert property (p_proto_read) else $error("protocol word read wrong");

   property p_rx_sets;
      i_rx_valid |=> o_comms_active;
   endproperty
   a_rx_sets: assert property (p_rx_sets) else $error("reception did not set comms");

   property p_idle_clears;
      (timer_expired && !o_active_protocol && !i_rx_valid) |=> !o_comms_active;
   endproperty
   a_idle_clears: assert property (p_idle_clears) else $error("idle timeout did not clear comms");

   property p_simple_poll;
      (i_half_duplex && i_rx_valid && !i_rx_cmd) |-> !timer_restart;
   endproperty
   a_simple_poll: assert property (p_simple_poll) else $error("simple poll restarted timer");

   property p_token_alone;
      (i_link_alone && o_active_protocol && !i_rx_valid && !i_proto_switch && !i_powerup) |=> !o_comms_active;
   endproperty
   a_token_alone: assert property (p_token_alone) else $error("lone station kept comms");

   property p_override;
      overrides && !i_major_err && !bad_output |=> !o_halted && o_mode == CSC_MODE_RUN && o_run_request;
   endproperty
   a_override: assert property (p_override) else $error("fault override did not recover");

   // A clear with no fault in the same cycle must really drop the sticky bit
   property p_irq_clear;
      (i_wr && i_addr == CSC_OFS_IRQ_CLR && i_wdata[CSC_I_FAULT] && !bad_output && !i_major_err)
         |=> !st_r.irq_stat[CSC_I_FAULT];
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("fault status not cleared");
endmodule

/* csc_pkg.sv */
// Constants shared by the controller status and configuration bank
package csc_pkg;
   localparam int unsigned CSC_ADDR_W = 3;
   localparam int unsigned CSC_DATA_W = 16;
   // Register indices
   localparam logic [2:0] CSC_OFS_PROTO = 3'h0;
   localparam logic [2:0] CSC_OFS_MODE = 3'h1;
   localparam logic [2:0] CSC_OFS_IRQ_STAT = 3'h2;
   localparam logic [2:0] CSC_OFS_IRQ_EN = 3'h3;
   localparam logic [2:0] CSC_OFS_IRQ_CLR = 3'h4;
   localparam logic [2:0] CSC_OFS_FAULT = 3'h5;
   localparam logic [2:0] CSC_OFS_MINOR = 3'h6;
   // Protocol configuration and status word bits
   localparam int unsigned CSC_B_EXT_IO = 8;
   localparam int unsigned CSC_B_PRIMARY = 10;
   localparam int unsigned CSC_B_ACTIVE = 11;
   localparam int unsigned CSC_B_HALF_DPX = 12;
   // Mode status word bits
   localparam int unsigned CSC_B_MODE_LSB = 0;
   localparam int unsigned CSC_B_FORCE_EN = 5;
   localparam int unsigned CSC_B_FORCE_IN = 6;
   localparam int unsigned CSC_B_COMMS = 7;
   localparam int unsigned CSC_B_FLT_OVR = 8;
   localparam int unsigned CSC_B_HALTED = 13;
   // Interrupt status bits
   localparam int unsigned CSC_IRQ_W = 3;
   localparam int unsigned CSC_I_FAULT = 0;
   localparam int unsigned CSC_I_COMMS_LOST = 1;
   localparam int unsigned CSC_I_PROTO_SW = 2;
   // Mode codes
   localparam logic [4:0] CSC_MODE_DOWNLOAD = 5'h00;
   localparam logic [4:0] CSC_MODE_PROGRAM = 5'h01;
   localparam logic [4:0] CSC_MODE_SUSPEND = 5'h03;
   localparam logic [4:0] CSC_MODE_RUN = 5'h06;
   localparam logic [4:0] CSC_MODE_TEST_CONT = 5'h07;
   localparam logic [4:0] CSC_MODE_TEST_SINGLE = 5'h08;
   // Protocol encodings
   localparam logic CSC_PROTO_SERIAL = 1'b0;
   localparam logic CSC_PROTO_TOKEN = 1'b1;
   // Fault codes
   localparam logic [15:0] CSC_FC_NO_OUTPUT = 16'h0041;
   // Reset values
   localparam logic CSC_RST_EXT_IO = 1'b0;
   localparam logic CSC_RST_PRIMARY = 1'b0;
   localparam logic CSC_RST_FLT_OVR = 1'b0;
   localparam logic [4:0] CSC_RST_MODE = 5'h01;
   // Timing
   localparam longint unsigned CSC_CLK_HZ = 10000000;
   localparam longint unsigned CSC_INACT_S = 10;
   localparam int unsigned CSC_INACT_CYC = int'(CSC_INACT_S * CSC_CLK_HZ);
endpackage

/* csc_idle_timer.sv */
// Inactivity timer: one-cycle pulse after COUNT cycles without a restart
`timescale 1ns/1ns
module csc_idle_timer #(
   parameter int unsigned COUNT = 100
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic i_restart,
   output logic o_expired
);
   typedef struct packed {
      logic [31:0] cnt;
      logic expired;
   } csc_tmr_s;

   csc_tmr_s st_r;
   csc_tmr_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.expired = 1'b0;
      if (!i_run || i_restart) begin
         st_nxt.cnt = 32'h00000000;
      end else if (st_r.cnt == COUNT - 1) begin
         // Fires once, then holds until the next restart
         st_nxt.expired = 1'b1;
         st_nxt.cnt = st_r.cnt + 32'h00000001;
      end else if (st_r.cnt < COUNT - 1) begin
         st_nxt.cnt = st_r.cnt + 32'h00000001;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_expired = st_r.expired;
endmodule

/* csc_term_model.sv */
// Programming terminal model: drives received-frame and link strobes into the bank
`timescale 1ns/1ns
module csc_term_model (
   input wire logic i_clk,
   output logic o_rx_valid,
   output logic o_rx_cmd,
   output logic o_link_alone
);
   logic cmd_r = 1'b0;
   logic idle_r = 1'b0;
   initial begin
      o_rx_valid = 1'b0;
      o_link_alone = 1'b0;
   end
   // Command line toggles between frames, so a stale level is never trusted
   always @(posedge i_clk) idle_r <= ~idle_r;
   assign o_rx_cmd = o_rx_valid ? cmd_r : idle_r;
   // A half-duplex master that wants comms held alive must send polls with a command
   task automatic send(input logic cmd);
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      cmd_r <= cmd;
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      #1;
   endtask
   task automatic alone();
      @(posedge i_clk);
      o_link_alone <= 1'b1;
      @(posedge i_clk);
      o_link_alone <= 1'b0;
      #1;
   endtask
endmodule

/* controller_status_config_bits_tb_top.sv */
// Self-checking bench for the controller status and configuration bank
`timescale 1ns/1ns
module controller_status_config_bits_tb_top import csc_pkg::*;;
   localparam int E_OUT = 0, E_MAJ = 1, E_MODE = 2, E_PWR = 3, E_SW = 4;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [2:0] addr = '0;
   logic [15:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_q = 1'b0;
   logic [4:0] ev = '0;
   logic [4:0] mcode = '0;
   logic [15:0] mjcode = '0;
   logic half = 1'b0;
   logic forces = 1'b0;
   logic out_exists = 1'b0;
   logic [7:0] mset = '0;
   logic rx_valid, rx_cmd, link_alone;
   logic [15:0] o_rdata;
   logic o_active_protocol, o_halted, o_comms_active, o_run_request, o_irq;
   logic [4:0] o_mode;
   logic [15:0] exp_q[$];
   logic [15:0] rnd;
   int n_errors = 0;
   int checks_done = 0;
   int cyc_cnt = 0;
   logic [4:0] codes[6] = '{5'h00, 5'h01, 5'h03, 5'h06, 5'h07, 5'h08};

   csc_status_bank #(.INACT_CYCLES(20)) u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(o_rdata), .i_out_wr(ev[E_OUT]), .i_out_exists(out_exists), .i_major_err(ev[E_MAJ]),
      .i_major_code(mjcode), .i_minor_set(mset), .i_mode_wr(ev[E_MODE]), .i_mode_code(mcode),
      .i_powerup(ev[E_PWR]), .i_proto_switch(ev[E_SW]), .i_half_duplex(half),
      .i_forces_installed(forces), .i_rx_valid(rx_valid), .i_rx_cmd(rx_cmd),
      .i_link_alone(link_alone), .o_active_protocol(o_active_protocol), .o_mode(o_mode),
      .o_halted(o_halted), .o_comms_active(o_comms_active), .o_run_request(o_run_request),
      .o_irq(o_irq)
   );
   csc_term_model u_term (
      .i_clk(i_clk), .o_rx_valid(rx_valid), .o_rx_cmd(rx_cmd), .o_link_alone(link_alone)
   );

   initial begin
      forever #50 i_clk = ~i_clk;
   end

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
      #1;
   endtask

   // Expectation is queued first; the watcher pops it when the data stand
   task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1;
   endtask

   task automatic pulse(input int k);
      @(posedge i_clk);
      ev[k] <= 1'b1;
      @(posedge i_clk);
      ev <= '0;
      #1;
   endtask

   always @(posedge i_clk) begin
      if (rd_q) chk("rdata", exp_q.pop_front(), o_rdata);
      rd_q <= rd;
   end

   always @(posedge i_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         n_errors++;
         stop_test();
      end
   end

   initial begin
      void'($urandom(51));
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      rd_reg(CSC_OFS_PROTO, 16'h0000);
      rd_reg(CSC_OFS_MODE, 16'h0021);
      rd_reg(3'h7, 16'h0000);
      wr_reg(CSC_OFS_PROTO, 16'hFFFF);
      rd_reg(CSC_OFS_PROTO, 16'h0500);
      wr_reg(CSC_OFS_MODE, 16'hC0DF);
      rd_reg(CSC_OFS_MODE, 16'h0021);
      forces <= 1'b1;
      foreach (codes[i]) begin
         mcode <= codes[i];
         pulse(E_MODE);
         chk("mode", {11'h0, codes[i]}, {11'h0, o_mode});
         rd_reg(CSC_OFS_MODE, 16'h0060 | codes[i]);
      end
      forces <= 1'b0;
      // Second poll lands before expiry; only full duplex may restart on it
      for (int h = 0; h < 2; h++) begin
         half <= h[0];
         rd_reg(CSC_OFS_PROTO, {3'h0, h[0], 12'h500});
         u_term.send(1'b1);
         chk("comms", 16'h1, {15'h0, o_comms_active});
         cyc(10);
         u_term.send(1'b0);
         cyc(14);
         chk("comms", {15'h0, ~h[0]}, {15'h0, o_comms_active});
         cyc(20);
         chk("comms", 16'h0, {15'h0, o_comms_active});
      end
      half <= 1'b0;
      pulse(E_SW);
      chk("active", 16'h1, {15'h0, o_active_protocol});
      rd_reg(CSC_OFS_PROTO, 16'h0D00);
      u_term.send(1'b1);
      cyc(30);
      chk("comms", 16'h1, {15'h0, o_comms_active});
      u_term.alone();
      chk("comms", 16'h0, {15'h0, o_comms_active});
      pulse(E_SW);
      wr_reg(CSC_OFS_IRQ_CLR, 16'h0007);
      wr_reg(CSC_OFS_IRQ_EN, 16'h0001);
      pulse(E_OUT);
      chk("halted", 16'h0, {15'h0, o_halted});
      wr_reg(CSC_OFS_PROTO, 16'h0400);
      // An output that really exists never faults, even without the extension bit
      out_exists <= 1'b1;
      pulse(E_OUT);
      chk("halted", 16'h0, {15'h0, o_halted});
      out_exists <= 1'b0;
      pulse(E_OUT);
      chk("halted", 16'h1, {15'h0, o_halted});
      chk("irq", 16'h1, {15'h0, o_irq});
      rd_reg(CSC_OFS_FAULT, CSC_FC_NO_OUTPUT);
      rd_reg(CSC_OFS_IRQ_STAT, 16'h0001);
      wr_reg(CSC_OFS_IRQ_CLR, 16'h0001);
      chk("irq", 16'h0, {15'h0, o_irq});
      pulse(E_SW);
      chk("irq", 16'h0, {15'h0, o_irq});
      rd_reg(CSC_OFS_IRQ_STAT, 16'h0004);
      pulse(E_SW);
      rnd = 16'($urandom());
      mjcode <= rnd;
      pulse(E_MAJ);
      rd_reg(CSC_OFS_FAULT, rnd);
      mcode <= CSC_MODE_PROGRAM;
      pulse(E_MODE);
      wr_reg(CSC_OFS_MODE, 16'h2100);
      mcode <= CSC_MODE_RUN;
      pulse(E_MODE);
      wr_reg(CSC_OFS_MINOR, {8'h0, rnd[7:0]});
      rd_reg(CSC_OFS_MINOR, {8'h0, rnd[7:0]});
      @(posedge i_clk);
      mset <= 8'h81;
      @(posedge i_clk);
      mset <= 8'h00;
      rd_reg(CSC_OFS_MINOR, {8'h0, rnd[7:0] | 8'h81});
      pulse(E_PWR);
      chk("run_req", 16'h1, {15'h0, o_run_request});
      chk("halted", 16'h0, {15'h0, o_halted});
      chk("active", 16'h1, {15'h0, o_active_protocol});
      rd_reg(CSC_OFS_MINOR, 16'h0000);
      rd_reg(CSC_OFS_MODE, 16'h0126);
      cyc(3);
      stop_test();
   end
endmodule
